// >>> shared/rds_pkg.sv
// Behaviour
// - rising enable starts on-delay, random between zero and maximum on-delay.
// - output sets only after on-delay elapses with enable held high throughout.
// - enable falling during on-delay clears the time; output stays clear.
// - falling enable starts off-delay, random between zero and maximum off-delay.
// - output clears after off-delay elapses with enable held low throughout.
// - enable rising during off-delay clears the time; output stays set.
// - after power loss, elapsed delay time restarts from zero.
package rds_pkg;

  // =====================================================
  // widths and timing
  localparam int          DLY_W        = 16;
  localparam int          LFSR_W       = 16;
  localparam int          TICK_US      = 1000;
  localparam int          CLK_MHZ      = 125;
  localparam int          TICK_CYC     = TICK_US * CLK_MHZ;
  localparam int          TICK_W       = 17;
  localparam logic [15:0] LFSR_SEED    = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS    = 16'hB400;
  localparam logic [15:0] DLY_ZERO     = 16'h0000;

  // =====================================================
  // state
  typedef enum logic [1:0] {
    RDS_IDLE_OFF = 2'b00,
    RDS_WAIT_ON  = 2'b01,
    RDS_IDLE_ON  = 2'b11,
    RDS_WAIT_OFF = 2'b10
  } rds_state_t;

  typedef struct packed {
    logic [DLY_W-1:0] max_on;
    logic [DLY_W-1:0] max_off;
  } rds_cfg_t;

endpackage : rds_pkg

// >>> core/rds_lfsr.sv
`timescale 1ns/100ps
module rds_lfsr
  import rds_pkg::*;
(
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              srst_i,
  // random word
  output logic [LFSR_W-1:0]      rnd_o
);

  logic [LFSR_W-1:0] lfsr_ff;
  logic [LFSR_W-1:0] nxt_lfsr;

  // free running galois shift, so edges see unrelated values
  always_comb begin
    nxt_lfsr = {1'b0, lfsr_ff[LFSR_W-1:1]} ^ (lfsr_ff[0] ? LFSR_TAPS : DLY_ZERO);
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lfsr_ff <= LFSR_SEED;
    end else begin
      lfsr_ff <= nxt_lfsr;
    end
  end

  assign rnd_o = lfsr_ff;

endmodule : rds_lfsr

// >>> core/rds_switch.sv
`timescale 1ns/100ps
module rds_switch
  import rds_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)(
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             srst_i,
  // control
  input  wire logic             enable_i,
  input  wire rds_cfg_t         cfg_i,
  // result
  output logic                  switch_o,
  output logic [DLY_W-1:0]      delay_o
);

  // =====================================================
  // enable synchroniser, enable comes from a pin
  logic             en_s1_ff;
  logic             en_s2_ff;
  logic             en_d_ff;
  logic             rise;
  logic             fall;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      en_s1_ff <= 1'b0;
      en_s2_ff <= 1'b0;
      en_d_ff  <= 1'b0;
    end else begin
      en_s1_ff <= enable_i;
      en_s2_ff <= en_s1_ff;
      en_d_ff  <= en_s2_ff;
    end
  end

  assign rise = en_s2_ff & ~en_d_ff;
  assign fall = ~en_s2_ff & en_d_ff;

  // =====================================================
  // random source
  // picked in the edge cycle, so the value depends on when enable moved
  logic [LFSR_W-1:0] rnd;

  rds_lfsr u_lfsr (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .rnd_o  (rnd)
  );

  // scale into 0..max by multiply and keep high half
  // (r+1)*max never passes max after the shift and needs no divider
  function automatic logic [DLY_W-1:0] scale(input logic [LFSR_W-1:0] r, input logic [DLY_W-1:0] mx);
    logic [LFSR_W+DLY_W:0] r_x;
    logic [LFSR_W+DLY_W:0] m_x;
    logic [LFSR_W+DLY_W:0] p;
    r_x = {{(DLY_W+1){1'b0}}, r};
    m_x = {{(LFSR_W+1){1'b0}}, mx};
    p   = r_x * m_x + m_x;
    return p[LFSR_W+DLY_W-1:LFSR_W];
  endfunction : scale

  // =====================================================
  // tick divider, one pulse per time unit
  logic [TICK_W-1:0] tick_ff;
  logic [TICK_W-1:0] nxt_tick;
  logic              tick;

  assign tick = (tick_ff == TICK_W'(TICK_CYCLES - 1));

  always_comb begin
    nxt_tick = tick ? '0 : tick_ff + 1'b1;
    if (rise || fall) begin
      nxt_tick = '0;
    end
  end

  // restart on every edge, so the first tick is a full period after it
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tick_ff <= '0;
    end else begin
      tick_ff <= nxt_tick;
    end
  end

  // =====================================================
  // delay state machine
  rds_state_t        st_ff;
  rds_state_t        nxt_st;
  logic [DLY_W-1:0]  tgt_ff;
  logic [DLY_W-1:0]  nxt_tgt;
  logic [DLY_W-1:0]  cnt_ff;
  logic [DLY_W-1:0]  nxt_cnt;
  logic              q_ff;
  logic              nxt_q;

  always_comb begin
    nxt_st  = st_ff;
    nxt_tgt = tgt_ff;
    nxt_cnt = cnt_ff;
    nxt_q   = q_ff;
    unique case (st_ff)
      RDS_IDLE_OFF, RDS_IDLE_ON: begin
        if (rise && !q_ff) begin
          nxt_st  = RDS_WAIT_ON;
          nxt_tgt = scale(rnd, cfg_i.max_on);
          nxt_cnt = DLY_ZERO;
        end else if (fall && q_ff) begin
          nxt_st  = RDS_WAIT_OFF;
          nxt_tgt = scale(rnd, cfg_i.max_off);
          nxt_cnt = DLY_ZERO;
        end
      end
      RDS_WAIT_ON: begin
        // abort wins over completion in the same cycle
        if (fall) begin
          nxt_st  = RDS_IDLE_OFF;
          nxt_cnt = DLY_ZERO;
        end else if (cnt_ff >= tgt_ff) begin
          nxt_st  = RDS_IDLE_ON;
          nxt_q   = 1'b1;
          nxt_cnt = DLY_ZERO;
        end else if (tick) begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      RDS_WAIT_OFF: begin
        if (rise) begin
          nxt_st  = RDS_IDLE_ON;
          nxt_cnt = DLY_ZERO;
        end else if (cnt_ff >= tgt_ff) begin
          nxt_st  = RDS_IDLE_OFF;
          nxt_q   = 1'b0;
          nxt_cnt = DLY_ZERO;
        end else if (tick) begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
    endcase
  end

  // nothing retained across reset, time restarts at zero
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_ff   <= RDS_IDLE_OFF;
      tgt_ff  <= DLY_ZERO;
      cnt_ff  <= DLY_ZERO;
      q_ff    <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      tgt_ff  <= nxt_tgt;
      cnt_ff  <= nxt_cnt;
      q_ff    <= nxt_q;
    end
  end

  assign switch_o = q_ff;
  assign delay_o  = tgt_ff;

  // =====================================================
  // checks
  chk_on_needs_high: assert property (@(posedge mclk_i) disable iff (srst_i)
    $rose(q_ff) |-> en_d_ff) else $error("output set while enable low");
  chk_off_needs_low: assert property (@(posedge mclk_i) disable iff (srst_i)
    $fell(q_ff) |-> !en_d_ff) else $error("output cleared while enable high");
  chk_on_abort: assert property (@(posedge mclk_i) disable iff (srst_i)
    (st_ff == RDS_WAIT_ON && fall) |=> (st_ff == RDS_IDLE_OFF && !q_ff)) else $error("on abort failed");
  chk_off_abort: assert property (@(posedge mclk_i) disable iff (srst_i)
    (st_ff == RDS_WAIT_OFF && rise) |=> (st_ff == RDS_IDLE_ON && q_ff)) else $error("off abort failed");
  chk_on_bound: assert property (@(posedge mclk_i) disable iff (srst_i)
    (st_ff == RDS_WAIT_ON) |-> (tgt_ff <= cfg_i.max_on)) else $error("on delay beyond max");
  chk_off_bound: assert property (@(posedge mclk_i) disable iff (srst_i)
    (st_ff == RDS_WAIT_OFF) |-> (tgt_ff <= cfg_i.max_off)) else $error("off delay beyond max");
  chk_count_reset: assert property (@(posedge mclk_i)
    srst_i |=> (cnt_ff == DLY_ZERO && !q_ff)) else $error("time kept over reset");
  chk_rise_starts: assert property (@(posedge mclk_i) disable iff (srst_i)
    (rise && !q_ff && st_ff != RDS_WAIT_OFF) |=> (st_ff == RDS_WAIT_ON && cnt_ff == DLY_ZERO))
    else $error("rise did not start delay");

  // =====================================================
  // delay steps: due, then settled
  sequence s_on_due;
    st_ff == RDS_WAIT_ON && !fall && cnt_ff >= tgt_ff;
  endsequence

  sequence s_on_done;
    st_ff == RDS_IDLE_ON && q_ff && cnt_ff == DLY_ZERO;
  endsequence

  sequence s_off_due;
    st_ff == RDS_WAIT_OFF && !rise && cnt_ff >= tgt_ff;
  endsequence

  sequence s_off_done;
    st_ff == RDS_IDLE_OFF && !q_ff && cnt_ff == DLY_ZERO;
  endsequence

  chk_on_completes: assert property (@(posedge mclk_i) disable iff (srst_i)
    s_on_due |=> s_on_done)
    else $error("on delay did not set output");
  chk_off_completes: assert property (@(posedge mclk_i) disable iff (srst_i)
    s_off_due |=> s_off_done)
    else $error("off delay did not clear output");

  // the output moves only at the end of its own delay
  chk_set_only_due: assert property (@(posedge mclk_i) disable iff (srst_i)
    (!q_ff && !(st_ff == RDS_WAIT_ON && !fall && cnt_ff >= tgt_ff)) |=> !q_ff)
    else $error("output set before on delay elapsed");
  chk_clear_only_due: assert property (@(posedge mclk_i) disable iff (srst_i)
    (q_ff && !(st_ff == RDS_WAIT_OFF && !rise && cnt_ff >= tgt_ff)) |=> q_ff)
    else $error("output cleared before off delay elapsed");

  // time advances once per tick and not otherwise
  chk_count_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
    (((st_ff == RDS_WAIT_ON && !fall) || (st_ff == RDS_WAIT_OFF && !rise)) && cnt_ff < tgt_ff && !tick)
    |=> $stable(cnt_ff))
    else $error("delay time moved without a tick");
  chk_count_step: assert property (@(posedge mclk_i) disable iff (srst_i)
    (((st_ff == RDS_WAIT_ON && !fall) || (st_ff == RDS_WAIT_OFF && !rise)) && cnt_ff < tgt_ff && tick)
    |=> (cnt_ff == $past(cnt_ff) + 1'b1))
    else $error("delay time missed a tick");

  // a new delay starts its time base from zero
  chk_tick_restart: assert property (@(posedge mclk_i) disable iff (srst_i)
    (rise || fall) |=> (tick_ff == '0))
    else $error("tick divider not restarted at edge");

endmodule : rds_switch

// >>> test/rds_switch_tb_top.sv
`timescale 1ns/100ps
module rds_switch_tb_top
  import rds_pkg::*;
;
  // =========
  // stimulus and checks
  logic             mclk_i = 1'b0;
  logic             srst_i = 1'b1;
  logic             enable_i = 1'b0;
  rds_cfg_t         cfg_i = '0;
  logic             switch_o;
  logic [DLY_W-1:0] delay_o;
  logic [DLY_W-1:0] d;
  int               err_total = 0;
  int               check_count = 0;
  int               cyc = 0;
  int               n;
  rds_cfg_t         rows [4] = '{{16'h0000, 16'h0000}, {16'h0008, 16'h0003},
                                 {16'h0005, 16'h0008}, {16'h0001, 16'h0002}};

  rds_switch #(.TICK_CYCLES(4)) rds_switch_i (
    .mclk_i(mclk_i), .srst_i(srst_i), .enable_i(enable_i),
    .cfg_i(cfg_i), .switch_o(switch_o), .delay_o(delay_o));

  initial forever #4 mclk_i = ~mclk_i;

  // hang guard well above the longest run
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  task summarize;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  task chk(input logic [DLY_W-1:0] seen, input logic [DLY_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task cyc_n(input int k);
    repeat (k) @(negedge mclk_i);
  endtask : cyc_n

  // one edge, then time the output against the chosen delay
  task step(input logic v, input logic [DLY_W-1:0] mx);
    enable_i = v;
    cyc_n(4);
    n = 4;
    d = delay_o;
    chk(16'(delay_o <= mx), 16'h0001);
    if (d > 0) chk(16'(switch_o), 16'(!v));
    while (switch_o !== v && n < 200) begin
      cyc_n(1);
      n++;
    end
    chk(16'(n), 16'(d * 4 + 4));
    chk(16'(switch_o), 16'(v));
  endtask : step

  initial begin
    cyc_n(4);
    chk(16'(switch_o), 16'h0000);
    chk(delay_o, 16'h0000);
    srst_i = 1'b0;
    for (int k = 0; k < 4; k++) begin
      cfg_i = rows[k];
      step(1'b1, rows[k].max_on);
      step(1'b0, rows[k].max_off);
      $display("row %0d done", k);
    end
    // drop enable inside the on-delay, then look past where it would have ended
    cfg_i = '{16'h0040, 16'h0000};
    enable_i = 1'b1;
    cyc_n(4);
    d = delay_o;
    enable_i = 1'b0;
    cyc_n(4 * d + 12);
    if (d > 0) chk(16'(switch_o), 16'h0000);
    $display("on abort done");
    cfg_i = '{16'h0000, 16'h0040};
    step(1'b1, 16'h0000);
    enable_i = 1'b0;
    cyc_n(4);
    d = delay_o;
    enable_i = 1'b1;
    cyc_n(4 * d + 12);
    if (d > 0) chk(16'(switch_o), 16'h0001);
    $display("off abort done");
    // reset mid-run drops output and time
    srst_i = 1'b1;
    cyc_n(2);
    chk(16'(switch_o), 16'h0000);
    chk(delay_o, 16'h0000);
    $display("reset done");
    summarize();
  end
endmodule : rds_switch_tb_top
